// ---- rtl/fesc_host.v ----
// Function
// - Poll ready bit, toggle enable between reads (no polling here; the test waits a fixed 220 cycles)
// - During suspend read other blocks, resume D0
// - Write latched on chip enable rising edge
// - Wait 480 ns after reset release
// - Unlock voltage 480 ns around write enable
`timescale 1ns/1ps
`include "fesc_defs.vh"

module fesc_host (
  input  wire        mclk,
  input  wire        rstn,
  input  wire        req_valid,
  input  wire        req_write,
  input  wire        req_unlock,
  input  wire [16:0] req_addr,
  input  wire [7:0]  req_data,
  input  wire        rp_release,
  output reg         req_ready,
  output reg         rsp_valid,
  output reg  [7:0]  rsp_data,
  output reg  [16:0] flash_addr,
  output reg  [7:0]  flash_dq_out,
  output reg         flash_dq_oe,
  input  wire [7:0]  flash_dq_in,
  output reg         flash_ce_n,
  output reg         flash_we_n,
  output reg         flash_oe_n,
  output reg         flash_oe_hv_en,
  output reg         reset_powerdown_pin_n
);

  // ****************************************
  // States.
  // ****************************************
  localparam [2:0] ST_RESET = 3'd0;
  localparam [2:0] ST_WAIT  = 3'd1;
  localparam [2:0] ST_IDLE  = 3'd2;
  localparam [2:0] ST_HVPRE = 3'd3;
  localparam [2:0] ST_PULSE = 3'd4;
  localparam [2:0] ST_HOLD  = 3'd5;
  localparam [2:0] ST_HVPST = 3'd6;
  localparam [2:0] ST_GAP   = 3'd7;

  // ****************************************
  // Cycle counts, cut to the counter width.
  // ****************************************
  localparam integer RP_CYC_I    = `FESC_RP_CE_CYC;
  localparam integer HV_CYC_I    = `FESC_HV_CYC;
  localparam integer PULSE_CYC_I = `FESC_PULSE_CYC;
  localparam integer HOLD_CYC_I  = `FESC_HOLD_CYC;

  localparam [8:0] RP_CYC    = RP_CYC_I[8:0];
  localparam [8:0] HV_CYC    = HV_CYC_I[8:0];
  localparam [8:0] PULSE_CYC = PULSE_CYC_I[8:0];
  localparam [8:0] HOLD_CYC  = HOLD_CYC_I[8:0];

  reg [2:0] state_q;
  reg [8:0] cnt_q;
  reg       wr_q;
  reg       hv_q;

  // ****************************************
  // Bus sequencer.
  // ****************************************
  always @(posedge mclk or negedge rstn) begin
    // ****************************************
    // Reset values.
    // ****************************************
    if (!rstn) begin
      state_q               <= ST_RESET;
      cnt_q                 <= 9'h000;
      wr_q                  <= 1'b0;
      hv_q                  <= 1'b0;
      req_ready             <= 1'b0;
      rsp_valid             <= 1'b0;
      rsp_data              <= 8'h00;
      flash_addr            <= 17'h00000;
      flash_dq_out          <= 8'h00;
      flash_dq_oe           <= 1'b0;
      flash_ce_n            <= 1'b1;
      flash_we_n            <= 1'b1;
      flash_oe_n            <= 1'b1;
      flash_oe_hv_en        <= 1'b0;
      reset_powerdown_pin_n <= 1'b0;
    end else begin
      // ****************************************
      // The response strobe lasts one cycle.
      // ****************************************
      rsp_valid <= 1'b0;
      case (state_q)
        // ****************************************
        // Hold the flash in reset.
        // ****************************************
        ST_RESET: begin
          if (rp_release) begin
            reset_powerdown_pin_n <= 1'b1;
            cnt_q                 <= RP_CYC;
            state_q               <= ST_WAIT;
          end
        end

        // ****************************************
        // Recovery time after reset release.
        // ****************************************
        ST_WAIT: begin
          if (cnt_q > 9'h001) begin
            cnt_q <= cnt_q - 9'h001;
          end else begin
            req_ready <= 1'b1;
            state_q   <= ST_IDLE;
          end
        end

        // ****************************************
        // Take a request.
        // ****************************************
        ST_IDLE: begin
          if (!rp_release) begin
            reset_powerdown_pin_n <= 1'b0;
            req_ready             <= 1'b0;
            state_q               <= ST_RESET;
          end else if (req_valid) begin
            req_ready    <= 1'b0;
            wr_q         <= req_write;
            hv_q         <= req_write & req_unlock;
            flash_addr   <= req_addr;
            flash_dq_out <= req_data;
            flash_dq_oe  <= req_write;
            if (req_write && req_unlock) begin
              flash_oe_hv_en <= 1'b1;
              cnt_q          <= HV_CYC;
              state_q        <= ST_HVPRE;
            end else begin
              flash_we_n <= ~req_write;
              cnt_q      <= PULSE_CYC;
              state_q    <= ST_PULSE;
            end
          end
        end

        // ****************************************
        // Unlock voltage setup before write enable.
        // ****************************************
        ST_HVPRE: begin
          if (cnt_q > 9'h001) begin
            cnt_q <= cnt_q - 9'h001;
          end else begin
            flash_we_n <= 1'b0;
            cnt_q      <= PULSE_CYC;
            state_q    <= ST_PULSE;
          end
        end

        // ****************************************
        // Chip enable pulse of full width.
        // ****************************************
        ST_PULSE: begin
          if (flash_ce_n) begin
            flash_ce_n <= 1'b0;
            flash_oe_n <= wr_q;
          end else if (cnt_q > 9'h001) begin
            cnt_q <= cnt_q - 9'h001;
          end else begin
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            if (!wr_q) begin
              rsp_data  <= flash_dq_in;
              rsp_valid <= 1'b1;
            end
            cnt_q   <= HOLD_CYC;
            state_q <= ST_HOLD;
          end
        end

        // ****************************************
        // Address and data hold after chip enable.
        // ****************************************
        ST_HOLD: begin
          if (cnt_q > 9'h001) begin
            cnt_q <= cnt_q - 9'h001;
          end else begin
            flash_we_n  <= 1'b1;
            flash_dq_oe <= 1'b0;
            cnt_q       <= HV_CYC;
            state_q     <= hv_q ? ST_HVPST : ST_GAP;
          end
        end

        // ****************************************
        // Unlock voltage hold after write enable.
        // ****************************************
        ST_HVPST: begin
          if (cnt_q > 9'h001) begin
            cnt_q <= cnt_q - 9'h001;
          end else begin
            flash_oe_hv_en <= 1'b0;
            state_q        <= ST_GAP;
          end
        end

        // ****************************************
        // Gap before the next request.
        // ****************************************
        ST_GAP: begin
          req_ready <= 1'b1;
          state_q   <= ST_IDLE;
        end
        default: begin
          state_q <= ST_RESET;
        end
      endcase
    end
  end

endmodule // fesc_host

// ---- inc/fesc_defs.vh ----
`ifndef FESC_DEFS_VH
`define FESC_DEFS_VH

// ****************************************
// Command codes.
// ****************************************
`define FESC_CMD_READ_ARRAY 8'hFF
`define FESC_CMD_READ_STAT  8'h70
`define FESC_CMD_CLR_STAT   8'h50
`define FESC_CMD_ERASE_SET  8'h20
`define FESC_CMD_CONFIRM    8'hD0
`define FESC_CMD_SUSPEND    8'hB0

// ****************************************
// Status bit positions.
// ****************************************
`define FESC_SR_READY   7
`define FESC_SR_SUSP    6
`define FESC_SR_ERASE   5
`define FESC_SR_PROG    4

// ****************************************
// Timing, in ns, and cycle counts at 100 MHz.
// ****************************************
`define FESC_CLK_NS        10
`define FESC_T_RP_CE_NS    480
`define FESC_T_HV_WE_NS    480
`define FESC_T_PULSE_NS    40
`define FESC_T_HOLD_NS     10
`define FESC_RP_CE_CYC  ((`FESC_T_RP_CE_NS + `FESC_CLK_NS - 1) / `FESC_CLK_NS)
`define FESC_HV_CYC     ((`FESC_T_HV_WE_NS + `FESC_CLK_NS - 1) / `FESC_CLK_NS)
`define FESC_PULSE_CYC  ((`FESC_T_PULSE_NS + `FESC_CLK_NS - 1) / `FESC_CLK_NS)
`define FESC_HOLD_CYC   ((`FESC_T_HOLD_NS + `FESC_CLK_NS - 1) / `FESC_CLK_NS)

`endif

// ---- sim/fesc_sva.sv ----
`timescale 1ns/1ps
module fesc_sva (
  input wire        mclk,
  input wire        rstn,
  input wire        rsp_valid,
  input wire [16:0] flash_addr,
  input wire        flash_ce_n,
  input wire        flash_we_n,
  input wire        flash_oe_n,
  input wire        flash_oe_hv_en,
  input wire        reset_powerdown_pin_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence ce_pulse;
    !flash_ce_n [*4] ##1 flash_ce_n;
  endsequence
  ce_width_a: assert property ($fell(flash_ce_n) |-> ce_pulse)
    else $error("chip enable pulse wrong");
  rd_answer_a: assert property ($fell(flash_oe_n) |-> ##4 rsp_valid)
    else $error("read answer late");
  wr_hold_a: assert property ($rose(flash_ce_n) && !flash_we_n
    |-> $stable(flash_addr) ##1 $stable(flash_addr) && $rose(flash_we_n))
    else $error("write hold wrong");
  rp_wait_a: assert property ($fell(flash_ce_n)
    |-> $past(reset_powerdown_pin_n, 48))
    else $error("reset recovery short");
  hv_setup_a: assert property ($fell(flash_we_n) && flash_oe_hv_en
    |-> $past(flash_oe_hv_en, 48))
    else $error("unlock setup short");
  hv_hold_a: assert property ($fell(flash_oe_hv_en)
    |-> $past(flash_we_n, 48))
    else $error("unlock hold short");
endmodule // fesc_sva
bind fesc_host fesc_sva chk_u (.mclk, .rstn, .rsp_valid, .flash_addr,
  .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_oe_hv_en,
  .reset_powerdown_pin_n);

// ---- sim/fesc_flash_model.sv ----
`timescale 1ns/1ps
module fesc_flash_model #(
  parameter ERASE_T = 200
) (
  input  wire        mclk,
  input  wire [16:0] a,
  input  wire [7:0]  d,
  input  wire        ce_n,
  input  wire        we_n,
  output wire [7:0]  q
);
  reg     [7:0] sr = 8'h80;
  reg           st = 1'b0;
  reg           es = 1'b0;
  integer       t  = 0;
  assign q = st ? sr : ~a[7:0];
  always @(negedge mclk) if (t > 0 && !sr[6]) begin
    t = t - 1;
    sr[7] = (t == 0);
  end
  always @(posedge ce_n) if (!we_n) begin
    if (es) begin
      es = 0;
      sr = (d == 8'hD0) ? 8'h00 : 8'hB0;
      t = (d == 8'hD0) ? ERASE_T : 0;
    end else case (d)
      8'hFF: st = 0;
      8'h70: st = 1;
      8'h50: sr = 8'h80;
      8'h20: es = 1;
      8'hB0: if (t > 0) sr = 8'hC0;
      8'hD0: if (sr[6]) sr = 8'h00;
      default: st = st;
    endcase
  end
endmodule // fesc_flash_model

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  `define CHK(n, e, s) begin checked = checked + 1; if ((s) !== (e)) begin \
    mismatches = mismatches + 1; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
  reg         mclk = 0, rstn = 0, rv = 0, rw = 0, ru = 0, rp = 0;
  reg  [16:0] ra = 0;
  reg  [7:0]  rd = 0;
  wire        rdy, rsv, oe, ce_n, we_n, oe_n, hv, rp_n;
  wire [7:0]  rsd, dqo, mq, bus;
  wire [16:0] fa;
  integer     mismatches = 0, checked = 0, n;
  assign bus = oe ? dqo : (!ce_n && !oe_n) ? mq : ~mq;
  fesc_host dut_u (.mclk(mclk), .rstn(rstn), .req_valid(rv), .req_write(rw),
    .req_unlock(ru), .req_addr(ra), .req_data(rd), .rp_release(rp),
    .req_ready(rdy), .rsp_valid(rsv), .rsp_data(rsd), .flash_addr(fa),
    .flash_dq_out(dqo), .flash_dq_oe(oe), .flash_dq_in(bus),
    .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
    .flash_oe_hv_en(hv), .reset_powerdown_pin_n(rp_n));
  fesc_flash_model flash_u (.mclk(mclk), .a(fa), .d(bus), .ce_n(ce_n),
    .we_n(we_n), .q(mq));
  initial forever #5 mclk = ~mclk;
  task op(input w, input u, input [16:0] ad, input [7:0] dt);
    begin
      @(negedge mclk);
      {rv, rw, ru, ra, rd} = {1'b1, w, u, ad, dt};
      for (n = 0; rdy !== 1'b1 && n < 300; n = n + 1) @(negedge mclk);
      @(negedge mclk);
      rv = 0;
      for (n = n; !w && rsv !== 1'b1 && n < 300; n = n + 1) @(negedge mclk);
      if (n >= 300) mismatches = mismatches + 1;
    end
  endtask
  task st;
    begin
      op(1, 0, 0, 8'h70);
      op(0, 0, 0, 8'h00);
    end
  endtask
  task t_susp;
    begin
      op(1, 0, 17'h1C000, 8'h20);
      op(1, 0, 17'h1C000, 8'hD0);
      st; `CHK("busy", 8'h00, rsd)
      op(1, 0, 17'h1C000, 8'hB0);
      st; `CHK("susp", 8'hC0, rsd)
      op(1, 0, 0, 8'hFF);
      op(0, 0, 17'h00055, 0); `CHK("array", 8'hAA, rsd)
      op(1, 0, 17'h1C000, 8'hD0);
      st; `CHK("resume", 8'h00, rsd)
      repeat (220) @(negedge mclk);
      st; `CHK("done", 8'h80, rsd)
    end
  endtask
  task t_bad;
    begin
      op(1, 0, 0, 8'h20);
      op(1, 0, 0, 8'hFF);
      st; `CHK("seq err", 8'hB0, rsd)
      op(1, 0, 0, 8'h50);
    end
  endtask
  task close_out;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    #100000 mismatches = mismatches + 1;
    close_out;
  end
  initial begin
    repeat (6) @(negedge mclk);
    rstn = 1;
    rp = 1;
    op(0, 0, 17'h00123, 0); `CHK("boot", 8'hDC, rsd)
    t_susp;
    t_bad;
    op(1, 1, 0, 8'h70);
    op(0, 0, 0, 0); `CHK("unlock", 8'h80, rsd)
    close_out;
  end
endmodule // tb_top
